// ### design/uhoes_top.sv
/*
 * OUT endpoint status and byte-count logic with a small receive FIFO.
 * Assumes the link layer delivers received bytes already framed per endpoint,
 * and that the lower control logic signals packet unload and FIFO byte reads.
 */

`timescale 1ns/1ps

module uhoes_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    // Fill is one bit wider than the pointers, so full and empty differ
    localparam logic [AW:0] FILL_FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (fill != FILL_FULL);
    assign out_valid_o = (fill != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule : uhoes_fifo

module uhoes_top (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // Received bytes from the link
    input  wire logic                         rx_valid_i,
    output logic                              rx_ready_o,
    input  wire uhoes_pkg::uhoes_rx_beat_s    rx_beat_i,
    input  wire logic [uhoes_pkg::MAXP_W-1:0] max_pkt_i,
    // Bytes into the packet memory
    output logic                              mem_valid_o,
    input  wire logic                         mem_ready_i,
    output uhoes_pkg::uhoes_rx_beat_s         mem_beat_o,
    // Controller side: selected endpoint, endpoint 0 strobes and DMA request
    input  wire logic                         out_rd_i,
    input  wire logic                         out_unload_i,
    output logic                              out_pkt_ready_o,
    input  wire logic                         ep0_rd_i,
    input  wire logic                         ep0_clr_i,
    output logic [uhoes_pkg::EP_W-1:0]        ep_select_o,
    output logic                              dma_req_o,
    output logic [uhoes_pkg::EP_W-1:0]        dma_ep_o
);
    localparam int F = uhoes_pkg::EP_FIRST;
    localparam int L = uhoes_pkg::EP_LAST;
    localparam int CW = uhoes_pkg::OUT_COUNT_W;
    // Endpoint 0 and unused indices see an all-zero control copy
    localparam logic [7:1] CSR_ZERO = uhoes_pkg::CSR_RESET;

    // Only endpoints 1 to 11 own an OUT control copy and packet slots
    function automatic logic is_out_ep(input logic [uhoes_pkg::EP_W-1:0] ep);
        return (ep >= uhoes_pkg::EP_W'(F)) && (ep <= uhoes_pkg::EP_W'(L));
    endfunction : is_out_ep

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [uhoes_pkg::EP_W-1:0]        ep_sel;
    logic [7:1]                        csr    [F:L];
    logic [L:F]                        incomp;
    logic [CW-1:0]                     cnt    [F:L][2];
    logic [1:0]                        npkt   [F:L];
    logic [L:F]                        hd;
    logic [CW-1:0]                     acc;
    logic [uhoes_pkg::EP0_COUNT_W-1:0] ep0_cnt;
    logic                              ack;

    // -----------------------------------------------------------------
    // Receive FIFO and drain decision
    // -----------------------------------------------------------------
    uhoes_pkg::uhoes_rx_beat_s bt;
    logic                      f_valid;
    logic                      f_pop;

    uhoes_fifo #(
        .WIDTH (uhoes_pkg::RX_BEAT_W),
        .DEPTH (uhoes_pkg::RX_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   (rx_beat_i),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop),
        .out_data_o  (bt)
    );

    wire         bt_out  = is_out_ep(bt.ep);
    wire         bt_ep0  = (bt.ep == '0);
    wire         drop    = !bt_out && !bt_ep0;
    wire [7:1]   bt_csr  = bt_out ? csr[bt.ep] : CSR_ZERO;
    wire [1:0]   bt_cap  = bt_csr[uhoes_pkg::BIT_DBL_BUF_DIS] ? 2'd1 : 2'd2;
    wire [1:0]   bt_npk  = bt_out ? npkt[bt.ep] : 2'd0;
    wire         room    = bt_ep0 ? (ep0_cnt != uhoes_pkg::EP0_COUNT_FULL) : (bt_npk < bt_cap);

    // Stalling here back-pressures the FIFO and so the link
    assign mem_valid_o = f_valid && !drop && room;
    assign mem_beat_o  = bt;
    assign f_pop       = f_valid && (drop || (room && mem_ready_i));

    wire         beat_out = f_pop && bt_out;
    wire         done     = beat_out && bt.last;
    wire [CW-1:0] next_acc = acc + 1'b1;
    // Length compare counts the last byte as well
    wire         full_sz  = (next_acc == CW'(max_pkt_i));
    wire         dma_hit  = bt_csr[uhoes_pkg::BIT_DMA_REQ_MODE] ? full_sz : 1'b1;

    // -----------------------------------------------------------------
    // Per-endpoint events
    // -----------------------------------------------------------------
    logic [L:F] done_v;
    logic [L:F] unl_v;
    logic [L:F] rd_v;
    logic [L:F] dbl_v;
    logic [L:F] wslot_v;

    always_comb begin
        for (int e = F; e <= L; e++) begin
            done_v[e]  = done && (bt.ep == uhoes_pkg::EP_W'(e));
            unl_v[e]   = out_unload_i && (ep_sel == uhoes_pkg::EP_W'(e)) && (npkt[e] != 2'd0);
            rd_v[e]    = out_rd_i && (ep_sel == uhoes_pkg::EP_W'(e));
            dbl_v[e]   = !csr[e][uhoes_pkg::BIT_DBL_BUF_DIS];
            wslot_v[e] = hd[e] ^ (dbl_v[e] && (npkt[e] != 2'd0));
        end
    end

    // -----------------------------------------------------------------
    // Register bus decode
    // -----------------------------------------------------------------
    wire [5:0] idx     = wb_adr_i[7:2];
    wire       req     = wb_cyc_i && wb_stb_i && !ack;
    wire       wr_lo   = req && wb_we_i && wb_sel_i[0];
    wire       sel_out = is_out_ep(ep_sel);
    wire       wr_csr  = wr_lo && (idx == uhoes_pkg::IDX_OUT_UPPER_CSR) && sel_out;
    wire       wr_sel  = wr_lo && (idx == uhoes_pkg::IDX_EP_SELECT);

    wire [7:1]    s_csr  = sel_out ? csr[ep_sel] : CSR_ZERO;
    wire          s_inc  = sel_out && incomp[ep_sel] && s_csr[uhoes_pkg::BIT_ISO];
    wire [CW-1:0] s_cnt  = sel_out ? cnt[ep_sel][hd[ep_sel]] : '0;
    wire [15:0]   cnt_rd = (ep_sel == '0) ? {9'h000, ep0_cnt}
                                          : {3'h0, s_cnt};
    logic [31:0]  rd_mux;

    always_comb begin
        unique case (idx)
            uhoes_pkg::IDX_EP_SELECT:     rd_mux = {28'h0000000, ep_sel};
            uhoes_pkg::IDX_OUT_UPPER_CSR: rd_mux = {24'h000000, s_csr, s_inc};
            uhoes_pkg::IDX_BYTE_COUNT:    rd_mux = {16'h0000, cnt_rd};
            default:                      rd_mux = 32'h00000000;
        endcase
    end

    assign wb_ack_o        = ack;
    assign ep_select_o     = ep_sel;
    assign out_pkt_ready_o = sel_out && (npkt[ep_sel] != 2'd0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack      <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ep_sel   <= '0;
        end else begin
            ack      <= req;
            wb_dat_o <= req ? rd_mux : 32'h00000000;
            if (wr_sel) begin
                ep_sel <= wb_dat_i[uhoes_pkg::EP_W-1:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Packet tracking
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc       <= '0;
            dma_req_o <= 1'b0;
            dma_ep_o  <= '0;
        end else begin
            acc       <= done ? '0 : (beat_out ? next_acc : acc);
            dma_req_o <= done && bt_csr[uhoes_pkg::BIT_DMA_REQ_EN] && dma_hit;
            dma_ep_o  <= done ? bt.ep : dma_ep_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int e = F; e <= L; e++) begin
                csr[e]    <= uhoes_pkg::CSR_RESET;
                npkt[e]   <= 2'd0;
                cnt[e][0] <= '0;
                cnt[e][1] <= '0;
            end
            hd     <= '0;
            incomp <= '0;
        end else begin
            for (int e = F; e <= L; e++) begin
                if (wr_csr && ep_sel == uhoes_pkg::EP_W'(e)) begin
                    csr[e] <= wb_dat_i[7:1];
                end
                if (unl_v[e] && !done_v[e]) begin
                    npkt[e] <= npkt[e] - 2'd1;
                end else if (done_v[e] && !unl_v[e]) begin
                    npkt[e] <= npkt[e] + 2'd1;
                end
                if (unl_v[e]) begin
                    hd[e] <= hd[e] ^ dbl_v[e];
                end
                if (done_v[e]) begin
                    cnt[e][wslot_v[e]] <= next_acc;
                end
                // A byte read from the head packet still counts while the other slot fills
                if (rd_v[e] && (cnt[e][hd[e]] != '0) && !(done_v[e] && (wslot_v[e] == hd[e]))) begin
                    cnt[e][hd[e]] <= cnt[e][hd[e]] - 1'b1;
                end
                // A new incomplete packet wins over a same-cycle clear
                if (done_v[e] && bt.incomplete && csr[e][uhoes_pkg::BIT_ISO]) begin
                    incomp[e] <= 1'b1;
                end else if (unl_v[e]) begin
                    incomp[e] <= 1'b0;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Endpoint 0 byte count
    // -----------------------------------------------------------------
    // Clear wins; a byte in and a byte out together leave the count as it is
    wire ep0_in = f_pop && bt_ep0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ep0_cnt <= '0;
        end else if (ep0_clr_i) begin
            ep0_cnt <= '0;
        end else if (ep0_in && !(ep0_rd_i && ep0_cnt != '0)) begin
            ep0_cnt <= ep0_cnt + 1'b1;
        end else if (!ep0_in && ep0_rd_i && ep0_cnt != '0) begin
            ep0_cnt <= ep0_cnt - 1'b1;
        end
    end
endmodule : uhoes_top

// ### include/uhoes_pkg.sv
/*
 * Constants and carrier types for the OUT endpoint status and byte-count block.
 * Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
 */
package uhoes_pkg;

    // -----------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // -----------------------------------------------------------------
    localparam logic [5:0] IDX_EP_SELECT     = 6'h0E;
    localparam logic [5:0] IDX_OUT_UPPER_CSR = 6'h17;
    localparam logic [5:0] IDX_BYTE_COUNT    = 6'h18;

    // -----------------------------------------------------------------
    // Fields of the upper OUT control/status register
    // -----------------------------------------------------------------
    localparam int BIT_DMA_REQ_EN   = 5;
    localparam int BIT_ISO          = 6;
    localparam int BIT_DMA_REQ_MODE = 3;
    localparam int BIT_DBL_BUF_DIS  = 1;
    localparam int BIT_INCOMP_RX    = 0;
    localparam logic [7:1] CSR_RESET = 7'h00;

    // -----------------------------------------------------------------
    // Field widths and limits
    // -----------------------------------------------------------------
    localparam int OUT_COUNT_W = 13;
    localparam int EP0_COUNT_W = 7;
    localparam int MAXP_W      = 11;
    localparam int EP_W        = 4;
    localparam int EP_FIRST    = 1;
    localparam int EP_LAST     = 11;
    localparam logic [EP0_COUNT_W-1:0] EP0_COUNT_FULL = 7'h7F;
    localparam int RX_FIFO_DEPTH = 4;

    // One received byte with its framing
    typedef struct packed {
        logic [7:0]      data;
        logic [EP_W-1:0] ep;
        logic            last;
        logic            incomplete;
    } uhoes_rx_beat_s;

    localparam int RX_BEAT_W = $bits(uhoes_rx_beat_s);

endpackage : uhoes_pkg

// ### verif/uhoes_properties.sv
/*
 * Checker of the OUT endpoint status block, on the top-level ports only.
 * Assumes a bind to uhoes_top that connects every port by name.
 */
`timescale 1ns/1ps

module uhoes_checker (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [7:0]                wb_adr_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      rx_ready_o,
    input wire logic                      mem_valid_o,
    input wire logic                      mem_ready_i,
    input wire uhoes_pkg::uhoes_rx_beat_s mem_beat_o,
    input wire logic                      dma_req_o,
    input wire logic [3:0]                ep_select_o
);
    // ------------------------------------------------
    // Read decode and sequences
    // ------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rd_ack = wb_ack_o && !wb_we_i;
    wire logic csr_rd = rd_ack && wb_adr_i[7:2] == uhoes_pkg::IDX_OUT_UPPER_CSR;
    wire logic cnt_rd = rd_ack && wb_adr_i[7:2] == uhoes_pkg::IDX_BYTE_COUNT;
    wire logic ep_ok  = ep_select_o >= 4'h1 && ep_select_o <= 4'hB;
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("no single ack after request");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data while idle");
    property p_cnt; cnt_rd && ep_select_o != 4'h0 |-> wb_dat_o[31:13] == 19'h0; endproperty
    a_cnt: assert property (p_cnt) else $error("out count upper bits set");
    property p_ep0; cnt_rd && ep_select_o == 4'h0 |-> wb_dat_o[31:7] == 25'h0; endproperty
    a_ep0: assert property (p_ep0) else $error("ep0 count upper bits set");
    property p_csr; csr_rd |-> wb_dat_o[31:8] == 24'h0 && (ep_ok || wb_dat_o == 32'h0); endproperty
    a_csr: assert property (p_csr) else $error("control copy read wrong");
    property p_dma; dma_req_o |-> $past(mem_valid_o && mem_ready_i && mem_beat_o.last); endproperty
    a_dma: assert property (p_dma) else $error("dma request without packet");
    property p_hold; mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_beat_o); endproperty
    a_hold: assert property (p_hold) else $error("drained byte not held");
    property p_rst; $fell(rst_i) |-> rx_ready_o && !mem_valid_o && ep_select_o == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    c_bus: cover property (s_req ##1 s_ack);
endmodule : uhoes_checker

// ### verif/uhoes_host_model.sv
/*
 * Link-side stand-in: sends framed OUT packets and sinks drained bytes.
 * Assumes the bench seeds $urandom and calls send from one process at a time.
 */
`timescale 1ns/1ps

module uhoes_host_model (
    input  wire logic                 clk_i,
    input  wire logic                 slow_i,
    input  wire logic                 rx_ready_i,
    output logic                      rx_valid_o,
    output uhoes_pkg::uhoes_rx_beat_s beat_o,
    output logic                      mem_ready_o
);
    // Bytes that must come out at the drain side, in order
    logic [7:0] sent [$];
    initial begin
        rx_valid_o = 1'b0;
        beat_o = '0;
        mem_ready_o = 1'b1;
    end
    always @(posedge clk_i) begin
        mem_ready_o <= !slow_i || ($urandom % 3 == 0);
    end
    task automatic send(input logic [3:0] ep, input int len, input logic inc);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        for (int i = 0; i < len; i++) begin
            beat_o <= {8'($urandom), ep, i == len - 1, inc};
            do @(posedge clk_i); while (rx_ready_i !== 1'b1);
            if (ep < 4'hC) sent.push_back(beat_o.data);
        end
        rx_valid_o <= 1'b0;
        // Idle beat scrambled so no stale last flag can be trusted
        beat_o <= ~beat_o;
    endtask : send
endmodule : uhoes_host_model

// ### verif/tb_top.sv
/*
 * Self-checking bench for the OUT endpoint status block.
 * Assumes the checker and host model are compiled before this file.
 */
`timescale 1ns/1ps

module tb_top;
    localparam logic [5:0] CSR = uhoes_pkg::IDX_OUT_UPPER_CSR;
    localparam logic [5:0] CNT = uhoes_pkg::IDX_BYTE_COUNT;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0, ack, rr, rv, mr, pr, dma;
    logic [7:0]  adr = 0, cfg = 0;
    logic [31:0] dat = 0, rdat, dat_o;
    logic [3:0]  sb = 0, sel = 0, ep_sel, dma_ep, last_ep;
    logic        mv;
    logic [10:0] maxp = 11'h008;
    uhoes_pkg::uhoes_rx_beat_s rb, mb;
    int          miscompares = 0, checks = 0, dmas = 0, exp_dma = 0, cycles = 0, q[$], v[12];
    initial forever #5 clk_i = ~clk_i;
    uhoes_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_valid_i(rv),
        .rx_ready_o(rr), .rx_beat_i(rb), .max_pkt_i(maxp), .mem_valid_o(mv), .mem_ready_i(mr),
        .mem_beat_o(mb), .out_rd_i(sb[0]), .out_unload_i(sb[1]), .out_pkt_ready_o(pr), .ep0_rd_i(sb[2]),
        .ep0_clr_i(sb[3]), .ep_select_o(ep_sel), .dma_req_o(dma), .dma_ep_o(dma_ep));
    uhoes_host_model host_u (.clk_i(clk_i), .slow_i(slow), .rx_ready_i(rr), .rx_valid_o(rv),
        .beat_o(rb), .mem_ready_o(mr));
    // ------------------------------------------------
    // Bus, strobe and packet tasks
    // ------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [5:0] i, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'hF, i, 2'b00, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rdc(input string n, input logic [5:0] i, input logic [31:0] e);
        wb(1'b0, i, 32'h0);
        chk(n, rdat, e);
    endtask : rdc
    task automatic pick(input int n);
        wb(1'b1, uhoes_pkg::IDX_EP_SELECT, n);
    endtask : pick
    task automatic strobe(input int k);
        @(posedge clk_i);
        sb <= 4'h1 << k;
        @(posedge clk_i);
        sb <= 4'h0;
    endtask : strobe
    task automatic pkt(input logic [3:0] e, input int n, input logic inc);
        q.push_back(n);
        if (cfg[5] && (!cfg[3] || n == maxp))
            exp_dma++;
        host_u.send(e, n, inc);
    endtask : pkt
    task automatic drain(input int n);
        repeat (n) begin
            repeat (2) @(posedge clk_i);
            for (int t = 0; t < 300 && pr !== 1'b1; t++) @(posedge clk_i);
            rdc("count", CNT, q[0]);
            strobe(0);
            rdc("count", CNT, q[0] - 1);
            strobe(1);
            void'(q.pop_front());
        end
    endtask : drain
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    always @(posedge clk_i) begin
        cycles++;
        if (dma === 1'b1) begin
            dmas++;
            last_ep = dma_ep;
        end
        if (mv === 1'b1 && mr === 1'b1) begin
            chk("mem_data", mb.data, host_u.sent.pop_front());
        end
        if (cycles == 30000) begin
            miscompares++;
            summarize();
        end
    end
    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial begin
        void'($urandom(1));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        pick(1);
        chk("ep_select", ep_sel, 1);
        rdc("csr", CSR, 0);
        rdc("unmapped", 6'h3F, 0);
        $display("test reset done");
        for (int n = 0; n < 12; n++) begin
            pick(n);
            v[n] = $urandom & 8'hFE;
            wb(1'b1, CSR, v[n]);
        end
        for (int n = 0; n < 12; n++) begin
            pick(n);
            rdc("csr", CSR, n ? v[n] : 0);
        end
        $display("test copies done");
        pick(1);
        maxp <= 11'(4 + $urandom % 8);
        for (int k = 0; k < 4; k++) begin
            cfg = (k < 2) ? 8'h20 : 8'h28;
            wb(1'b1, CSR, cfg);
            pkt(1, (k < 2) ? 1 + $urandom % 20 : maxp - 3 + 3 * (k - 2), 1'b0);
            drain(1);
            chk("dma", dmas, exp_dma);
        end
        chk("dma_ep", last_ep, 1);
        $display("test dma done");
        // Second packet only fits when double buffered; else the FIFO fills up
        pick(2);
        slow <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            cfg = k << 1;
            wb(1'b1, CSR, cfg);
            pkt(2, 3, 1'b0);
            fork
                pkt(2, 5, 1'b0);
            join_none
            repeat (60) @(posedge clk_i);
            chk("rx_ready", rr, !k);
            drain(2);
        end
        slow <= 1'b0;
        $display("test buffering done");
        pick(3);
        for (int k = 0; k < 2; k++) begin
            cfg = k ? 8'h40 : 8'h00;
            wb(1'b1, CSR, cfg);
            pkt(3, 4, 1'b1);
            repeat (30) @(posedge clk_i);
            rdc("incomplete", CSR, cfg | k);
            drain(1);
            rdc("incomplete", CSR, cfg);
        end
        $display("test incomplete done");
        pick(0);
        host_u.send(0, 5, 1'b0);
        host_u.send(12, 3, 1'b0);
        repeat (20) @(posedge clk_i);
        rdc("ep0_count", CNT, 5);
        strobe(2);
        rdc("ep0_count", CNT, 4);
        strobe(3);
        rdc("ep0_count", CNT, 0);
        $display("test ep0 done");
        summarize();
    end
endmodule : tb_top

bind uhoes_top uhoes_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_ready_o(rx_ready_o),
    .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i), .mem_beat_o(mem_beat_o), .dma_req_o(dma_req_o),
    .ep_select_o(ep_select_o));
